// [rtl/esr_pkg.sv]
// Package for the entropy source with hybrid deterministic generator.
// Assumes one clock domain; shared constants for health tests and word sizes.
package esr_pkg;
  localparam int unsigned WORD_W = 32;
  localparam int unsigned STATE_W = 128;
  localparam int unsigned CNT_W = 16;
  // Raw bits gathered per word.
  localparam int unsigned BITS_PER_WORD = 32;
  // Repetition limit: a run of this many equal raw bits is allowed; the next equal bit is a total failure.
  localparam int unsigned STUCK_LIMIT = 32;
  // Online test window and acceptable count of ones in it.
  localparam int unsigned WIN_LEN = 256;
  localparam int unsigned ONES_LO = 96;
  localparam int unsigned ONES_HI = 160;
  // Seed words drawn from the physical source per (re)seed.
  localparam int unsigned SEED_WORDS = 4;
  localparam logic [STATE_W-1:0] STATE_RST = 128'h0;
  typedef enum logic [1:0] {
    ESR_ST_STARTUP,
    ESR_ST_RUN,
    ESR_ST_FAIL
  } esr_health_t;
endpackage : esr_pkg

// [rtl/esr_health.sv]
// Health test for the raw entropy bit stream: total-failure and online tests.
// Assumes raw bits arrive already synchronised, one bit per raw_vld pulse.
`timescale 1ns/1ns
module esr_health (
  input wire logic clk,
  input wire logic rst,
  input wire logic raw_bit,
  input wire logic raw_vld,
  output logic healthy,
  output logic fail_pulse
);
  logic last_q;
  logic [esr_pkg::CNT_W-1:0] run_q;
  logic [esr_pkg::CNT_W-1:0] win_q;
  logic [esr_pkg::CNT_W-1:0] ones_q;
  logic passed_q;
  logic stuck;
  logic win_end;
  logic win_bad;
  logic [esr_pkg::CNT_W-1:0] ones_next;

  assign stuck = raw_vld && (raw_bit == last_q) &&
                 (run_q == esr_pkg::CNT_W'(esr_pkg::STUCK_LIMIT - 1));
  assign ones_next = ones_q + esr_pkg::CNT_W'(raw_bit);
  assign win_end = raw_vld && (win_q == esr_pkg::CNT_W'(esr_pkg::WIN_LEN - 1));
  assign win_bad = win_end && ((ones_next < esr_pkg::CNT_W'(esr_pkg::ONES_LO)) ||
                               (ones_next > esr_pkg::CNT_W'(esr_pkg::ONES_HI)));
  assign fail_pulse = stuck || win_bad;
  assign healthy = passed_q && !fail_pulse;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      last_q <= 1'b0;
      run_q <= '0;
    end else if (raw_vld) begin
      last_q <= raw_bit;
      run_q <= (raw_bit == last_q) ? run_q + 1'b1 : '0;
    end
  end

  // The window runs for as long as the source does, so defects are seen within one window.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      win_q <= '0;
      ones_q <= '0;
    end else if (raw_vld) begin
      win_q <= win_end ? '0 : win_q + 1'b1;
      ones_q <= win_end ? '0 : ones_next;
    end
  end

  // The first clean window is the power-up online test.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      passed_q <= 1'b0;
    end else if (fail_pulse) begin
      passed_q <= 1'b0;
    end else if (win_end) begin
      passed_q <= 1'b1;
    end
  end
endmodule : esr_health

// [rtl/esr_top.sv]
// Top of the entropy source: health-gated physical words and a seeded
// deterministic generator. Assumes raw_bit comes from an asynchronous source.
`timescale 1ns/1ns
//////////////////////////////////////////////////////////////////////////////
module esr_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic raw_bit,
  input wire logic raw_vld,
  input wire logic phys_req,
  input wire logic [esr_pkg::CNT_W-1:0] phys_count,
  output logic [esr_pkg::WORD_W-1:0] phys_data,
  output logic phys_valid,
  output logic phys_busy,
  input wire logic det_req,
  input wire logic reseed_req,
  output logic [esr_pkg::WORD_W-1:0] det_data,
  output logic det_valid,
  output logic det_seeded,
  output logic fail_flag
);
  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and health test.
  logic [1:0] bit_s_q;
  logic [1:0] vld_s_q;
  logic vld_d_q;
  logic rb;
  logic rv;
  logic healthy;
  logic fail_pulse;
  esr_pkg::esr_health_t health_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bit_s_q <= '0;
      vld_s_q <= '0;
      vld_d_q <= 1'b0;
    end else begin
      bit_s_q <= {bit_s_q[0], raw_bit};
      vld_s_q <= {vld_s_q[0], raw_vld};
      vld_d_q <= vld_s_q[1];
    end
  end
  assign rb = bit_s_q[1];
  assign rv = vld_s_q[1] && !vld_d_q;

  esr_health u_health (
    .clk(clk),
    .rst(rst),
    .raw_bit(rb),
    .raw_vld(rv),
    .healthy(healthy),
    .fail_pulse(fail_pulse)
  );

  // Failure is terminal: a source that once failed is not trusted again until reset.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      health_q <= esr_pkg::ESR_ST_STARTUP;
    end else begin
      case (health_q)
        esr_pkg::ESR_ST_STARTUP: begin
          if (fail_pulse) begin
            health_q <= esr_pkg::ESR_ST_FAIL;
          end else if (healthy) begin
            health_q <= esr_pkg::ESR_ST_RUN;
          end
        end
        esr_pkg::ESR_ST_RUN: begin
          if (fail_pulse) begin
            health_q <= esr_pkg::ESR_ST_FAIL;
          end
        end
        esr_pkg::ESR_ST_FAIL: health_q <= esr_pkg::ESR_ST_FAIL;
        default: health_q <= esr_pkg::ESR_ST_FAIL;
      endcase
    end
  end
  assign fail_flag = (health_q == esr_pkg::ESR_ST_FAIL);

  //////////////////////////////////////////////////////////////////////////////
  // Word assembly from raw bits.
  logic [esr_pkg::WORD_W-1:0] sh_q;
  logic [5:0] nb_q;
  logic word_rdy;
  logic word_take;
  logic ok;

  assign ok = (health_q == esr_pkg::ESR_ST_RUN) && !fail_pulse;
  assign word_rdy = (nb_q == 6'(esr_pkg::BITS_PER_WORD));

  // A failure throws away the partial word so no bit after it reaches an output.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sh_q <= '0;
      nb_q <= '0;
    end else if (fail_pulse || health_q != esr_pkg::ESR_ST_RUN) begin
      nb_q <= '0;
    end else if (word_take) begin
      nb_q <= '0;
    end else if (rv && !word_rdy) begin
      sh_q <= {sh_q[esr_pkg::WORD_W-2:0], rb};
      nb_q <= nb_q + 6'h01;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Physical path: a counted burst of words.
  logic [esr_pkg::CNT_W-1:0] left_q;
  logic seed_busy;
  logic phys_take;

  assign phys_busy = (left_q != '0);
  assign phys_take = ok && word_rdy && phys_busy && !seed_busy;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      left_q <= '0;
    end else if (phys_req && !phys_busy) begin
      left_q <= phys_count;
    end else if (phys_take) begin
      left_q <= left_q - 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phys_data <= '0;
      phys_valid <= 1'b0;
    end else begin
      phys_valid <= phys_take;
      if (phys_take) begin
        phys_data <= sh_q;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Deterministic path.
  logic [esr_pkg::STATE_W-1:0] st_q;
  logic [2:0] seed_n_q;
  logic seeded_q;
  logic reseed_pend_q;
  logic seed_take;
  logic seed_last;
  logic det_fire;
  logic [esr_pkg::STATE_W-1:0] mix;

  assign seed_busy = reseed_pend_q || !seeded_q;
  assign seed_take = ok && word_rdy && seed_busy;
  assign seed_last = (seed_n_q == 3'(esr_pkg::SEED_WORDS - 1));
  assign word_take = phys_take || seed_take;
  assign det_fire = det_req && seeded_q && !reseed_pend_q &&
                    (health_q == esr_pkg::ESR_ST_RUN);

  // Rotate-add-xor mixing; the output word is folded away from the kept state.
  function automatic logic [esr_pkg::STATE_W-1:0] esr_mix(
    input logic [esr_pkg::STATE_W-1:0] s
  );
    logic [esr_pkg::STATE_W-1:0] a;
    a = s ^ {s[86:0], s[127:87]};
    a = a + {a[40:0], a[127:41]} + 128'h9E3779B97F4A7C15F39CC0605CEDC835;
    return a ^ {a[100:0], a[127:101]} ^ (a >> 7);
  endfunction : esr_mix

  assign mix = esr_mix(st_q);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= esr_pkg::STATE_RST;
    end else if (seed_take) begin
      st_q <= esr_mix({st_q[95:0], st_q[127:96] ^ sh_q});
    end else if (det_fire) begin
      st_q <= mix ^ {mix[63:0], mix[127:64]};
    end
  end

  // A new reseed request restarts the count, so every reseed mixes in all its words fresh.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      seed_n_q <= '0;
    end else if (reseed_req && seeded_q) begin
      seed_n_q <= '0;
    end else if (seed_take) begin
      seed_n_q <= seed_last ? '0 : seed_n_q + 3'h1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      seeded_q <= 1'b0;
    end else if (seed_take && seed_last) begin
      seeded_q <= 1'b1;
    end
  end

  // A request in the cycle that ends a reseed wins, so it is never lost.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reseed_pend_q <= 1'b0;
    end else if (reseed_req && seeded_q) begin
      reseed_pend_q <= 1'b1;
    end else if (seed_take && seed_last) begin
      reseed_pend_q <= 1'b0;
    end
  end
  assign det_seeded = seeded_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      det_data <= '0;
      det_valid <= 1'b0;
    end else begin
      det_valid <= det_fire;
      if (det_fire) begin
        det_data <= mix[127:96] ^ mix[31:0];
      end
    end
  end
endmodule : esr_top

// [verification/esr_monitor.sv]
// Checker for esr_top: output gating, strobes and sticky failure.
// Assumes one clock and an active-high asynchronous reset.
`timescale 1ns/1ns
module esr_monitor (
  input wire logic clk,
  input wire logic rst,
  input wire logic raw_vld,
  input wire logic det_req,
  input wire logic reseed_req,
  input wire logic [esr_pkg::WORD_W-1:0] phys_data,
  input wire logic phys_valid,
  input wire logic phys_busy,
  input wire logic det_valid,
  input wire logic det_seeded,
  input wire logic fail_flag
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Pin edges lead the synchronised ones, so this count never lags the design.
  logic [8:0] rise_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rise_q <= 9'h000;
    end else if ($rose(raw_vld) && !rise_q[8]) begin
      rise_q <= rise_q + 9'h001;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  startup_quiet_a: assert property (!rise_q[8] |-> !phys_valid && !det_valid)
    else $error("word released before the startup window");
  fail_blocks_a: assert property ($past(fail_flag) |-> !phys_valid && !det_valid)
    else $error("word released after failure");
  fail_sticky_a: assert property (fail_flag |=> fail_flag)
    else $error("failure flag cleared");
  det_seeded_a: assert property (det_valid |-> det_seeded && $past(det_req))
    else $error("det word without seed or request");
  seed_keep_a: assert property (det_seeded |=> det_seeded)
    else $error("seeded flag dropped");
  reseed_block_a: assert property (reseed_req && det_seeded |-> ##2 !det_valid)
    else $error("det word during reseed");
  phys_gap_a: assert property (phys_valid |-> $past(phys_busy) ##1 !phys_valid)
    else $error("phys strobe malformed");
  data_hold_a: assert property ($changed(phys_data) |-> phys_valid)
    else $error("phys data moved without strobe");
  phys_seen_c: cover property (phys_valid);
  det_seen_c: cover property (det_valid);
  fail_seen_c: cover property ($rose(fail_flag));
endmodule : esr_monitor
bind esr_top esr_monitor u_esr_monitor (.clk(clk), .rst(rst), .raw_vld(raw_vld),
  .det_req(det_req), .reseed_req(reseed_req), .phys_data(phys_data),
  .phys_valid(phys_valid), .phys_busy(phys_busy), .det_valid(det_valid),
  .det_seeded(det_seeded), .fail_flag(fail_flag));

// [verification/esr_src_model.sv]
// Raw entropy source model: one bit every 4 clocks, balanced or stuck high.
// Assumes the block synchronises raw_bit and raw_vld itself.
`timescale 1ns/1ns
module esr_src_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic stuck,
  output logic raw_bit,
  output logic raw_vld
);
  // A 7-bit LFSR keeps runs short and any 256-bit window near half ones.
  logic [6:0] lfsr_q;
  logic [1:0] ph_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lfsr_q <= 7'h01;
      ph_q <= 2'h0;
    end else begin
      ph_q <= ph_q + 2'h1;
      if (ph_q == 2'h3) begin
        lfsr_q <= {lfsr_q[5:0], lfsr_q[6] ^ lfsr_q[5]};
      end
    end
  end
  assign raw_vld = ph_q[1];
  assign raw_bit = stuck | lfsr_q[6];
endmodule : esr_src_model

// [verification/tb_top.sv]
// Testbench for esr_top with a raw source model on the entropy input.
// Assumes the design files compile first.
`timescale 1ns/1ns
module tb_top;
  logic clk, rst, stuck, raw_bit, raw_vld, phys_req, det_req, reseed_req;
  logic phys_valid, phys_busy, det_valid, det_seeded, fail_flag;
  logic [15:0] phys_count;
  logic [31:0] phys_data, det_data, last_det;
  int fail_count, checks, cyc, pv_n, dv_n, same_n, i;
  esr_src_model u_esr_src_model (.clk(clk), .rst(rst), .stuck(stuck), .raw_bit(raw_bit),
    .raw_vld(raw_vld));
  esr_top u_esr_top (.clk(clk), .rst(rst), .raw_bit(raw_bit), .raw_vld(raw_vld),
    .phys_req(phys_req), .phys_count(phys_count), .phys_data(phys_data),
    .phys_valid(phys_valid), .phys_busy(phys_busy), .det_req(det_req),
    .reseed_req(reseed_req), .det_data(det_data), .det_valid(det_valid),
    .det_seeded(det_seeded), .fail_flag(fail_flag));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Counting on the falling edge keeps clear of the registered outputs.
  always @(negedge clk) begin
    if (phys_valid === 1'b1) begin
      pv_n++;
      // Source bits obey o(n+7) = o(n) ^ o(n+1); only MSB-first order keeps it in the word.
      chk({7'h00, phys_data[24:0]}, {7'h00, phys_data[31:7] ^ phys_data[30:6]});
      chk(phys_data === 32'h0, 1'b0);
    end
    if (det_valid === 1'b1) begin
      dv_n++;
      if (det_data === last_det) same_n++;
      last_det = det_data;
    end
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 12000) begin
      fail_count++;
      results();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic do_reset(input logic s);
    rst = 1'b1;
    stuck = s;
    tick(6);
    rst = 1'b0;
    pv_n = 0;
    dv_n = 0;
  endtask : do_reset
  task automatic results();
    if (fail_count == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : results
  ////////////////////////////////////////////////////////////////////////////
  task automatic startup_fail();
    do_reset(1'b1);
    det_req = 1'b1;
    phys_count = 16'h0001;
    phys_req = 1'b1;
    tick(1600);
    {phys_req, det_req} = 2'h0;
    chk(fail_flag, 1);
    chk(det_seeded, 0);
    chk(pv_n + dv_n, 0);
  endtask : startup_fail
  task automatic seed_up();
    do_reset(1'b0);
    det_req = 1'b1;
    tick(900);
    det_req = 1'b0;
    chk(dv_n, 0);
    chk(det_seeded, 0);
    for (i = 0; i < 1500 && det_seeded !== 1'b1; i++) tick(1);
    chk(det_seeded, 1);
    chk(fail_flag, 0);
  endtask : seed_up
  task automatic det_burst();
    dv_n = 0;
    det_req = 1'b1;
    tick(3);
    det_req = 1'b0;
    tick(2);
    chk(dv_n, 3);
    chk(same_n, 0);
  endtask : det_burst
  task automatic reseed();
    reseed_req = 1'b1;
    tick(1);
    reseed_req = 1'b0;
    det_req = 1'b1;
    dv_n = 0;
    tick(300);
    chk(dv_n, 0);
    for (i = 0; i < 1200 && dv_n == 0; i++) tick(1);
    det_req = 1'b0;
    chk(dv_n != 0, 1);
  endtask : reseed
  task automatic phys_burst();
    pv_n = 0;
    phys_count = 16'h0002;
    phys_req = 1'b1;
    tick(1);
    phys_req = 1'b0;
    chk(phys_busy, 1);
    for (i = 0; i < 600 && phys_busy !== 1'b0; i++) tick(1);
    chk(phys_busy, 0);
    tick(2);
    chk(pv_n, 2);
  endtask : phys_burst
  task automatic run_fail();
    stuck = 1'b1;
    for (i = 0; i < 400 && fail_flag !== 1'b1; i++) tick(1);
    chk(fail_flag, 1);
    {pv_n, dv_n} = 64'h0;
    {phys_req, det_req} = 2'h3;
    tick(300);
    {phys_req, det_req, stuck} = 3'h0;
    tick(200);
    chk(pv_n + dv_n, 0);
    chk(fail_flag, 1);
  endtask : run_fail
  initial begin
    {rst, stuck, phys_req, det_req, reseed_req} = 5'h10;
    phys_count = 16'h0000;
    last_det = 32'h0;
    startup_fail();
    seed_up();
    det_burst();
    reseed();
    phys_burst();
    run_fail();
    results();
  end
endmodule : tb_top
